/* File: hdl/spl_params.svh */
// constants of the software position limit block: offsets, fields, resets, figures
// assumes word-aligned byte addresses on the plain register port
`ifndef SPL_PARAMS_SVH
`define SPL_PARAMS_SVH

// register byte addresses
`define SPL_A_CTRL     8'h00
`define SPL_A_UPPER    8'h04
`define SPL_A_LOWER    8'h08
`define SPL_A_HOFF     8'h0c
`define SPL_A_OBJ_MIN  8'h10
`define SPL_A_OBJ_MAX  8'h14
`define SPL_A_STATUS   8'h18
`define SPL_A_SWRST    8'h1c

// control field positions
`define SPL_F_MODE_LO  0
`define SPL_F_MODE_HI  2
`define SPL_F_UNIT_LO  4
`define SPL_F_UNIT_HI  5
`define SPL_F_ERASE    8

// status field positions
`define SPL_F_WARN     0
`define SPL_F_CMDERR   1
`define SPL_F_HOMEV    2
`define SPL_F_ABSER    3
`define SPL_F_ACTIVE   4
`define SPL_F_KEYERR   5

// reset values
`define SPL_RST_LIMIT  32'h00000000
`define SPL_RST_HOFF   32'h00000000
`define SPL_HOME_ADDR  36'sh000000000

// figures
`define SPL_RST_KEY    32'h00001ea5
`define SPL_DEG_FULL   36'sh000057e40
`define SPL_DEG_FULL32 32'h00057e40
`define SPL_MAX32      36'sh07fffffff
`define SPL_MIN32      -36'sh080000000
`define SPL_OVER_HI    36'sh01fffffff
`define SPL_OVER_LO    36'sh020000000

`endif

/* File: hdl/spl_pkg.sv */
// types of the software position limit block
// assumes spl_params.svh supplies the numeric constants
package spl_pkg;

   typedef enum logic [2:0]
   {
      SPL_M_CSP  = 3'h0,
      SPL_M_PP   = 3'h1,
      SPL_M_PT   = 3'h2,
      SPL_M_JOG  = 3'h3,
      SPL_M_HOME = 3'h4,
      SPL_M_VEL  = 3'h5,
      SPL_M_TRQ  = 3'h6
   } spl_mode_e;

   typedef enum logic [1:0]
   {
      SPL_U_MM    = 2'h0,
      SPL_U_INCH  = 2'h1,
      SPL_U_DEG   = 2'h2,
      SPL_U_PULSE = 2'h3
   } spl_unit_e;

   typedef struct packed
   {
      logic [31:0] upper;
      logic [31:0] lower;
      logic [31:0] hoff;
      spl_mode_e   mode;
      spl_unit_e   unit;
      logic        erase_opt;
      logic        obj_dis;
      logic        home_valid;
      logic        abs_erased;
      logic        warn;
      logic        cmd_err;
      logic        key_err;
      logic [31:0] eff_pos;
      logic        eff_vld;
      logic [31:0] rdata;
   } spl_state_s;

endpackage : spl_pkg

/* File: hdl/spl_top.sv */
// software position limit: clamps commanded positions, flags range errors
// assumes commands and register strobes come from logic on clk_i
// assumes home_done_i is a one-cycle pulse from the homing sequencer
// limitation: degree units carry no overshoot check, only linear ones do
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "spl_params.svh"

module spl_top
(
   input  wire logic               clk_i,
   input  wire logic               sys_rst_i,
   input  wire logic        [7:0]  addr_i,
   input  wire logic        [31:0] wdata_i,
   input  wire logic               wr_i,
   input  wire logic               rd_i,
   output logic             [31:0] rdata_o,
   input  wire logic signed [33:0] cmd_pos_i,
   input  wire logic               cmd_vld_i,
   input  wire logic               home_done_i,
   output logic             [31:0] eff_pos_o,
   output logic                    eff_vld_o,
   output logic                    limit_clamp_warning_o,
   output logic                    command_range_error_o,
   output logic                    abs_position_erased_out_o,
   output logic                    home_valid_o,
   output logic                    limit_active_o
);

   spl_pkg::spl_state_s st_r;
   spl_pkg::spl_state_s st_nxt;

   logic signed [35:0] cmd_w;
   logic signed [35:0] hi_w;
   logic signed [35:0] lo_w;
   logic signed [35:0] over_hi_w;
   logic signed [35:0] over_lo_w;
   logic        [31:0] p_d;
   logic        [31:0] hi_d;
   logic        [31:0] lo_d;
   logic               inside_d;
   logic               near_lo_d;
   logic               is_deg;
   logic               en_w;
   logic               mode_ok;
   logic               act_w;
   logic               csp_err_w;
   logic               above_w;
   logic               below_w;
   logic               over_w;
   logic               deg_clamp_w;
   logic        [31:0] deg_out_w;

   // modulo 360 in thousandths; the remainder keeps the dividend sign
   function automatic logic [31:0] deg_norm(input logic signed [35:0] v);
      logic signed [35:0] r;
      r = v % `SPL_DEG_FULL;
      if (r < `SPL_HOME_ADDR)
      begin
         r = r + `SPL_DEG_FULL;
      end
      return r[31:0];
   endfunction : deg_norm

   // counter-clockwise distance from b up to a, both already normalised
   function automatic logic [31:0] deg_dist(input logic [31:0] a, input logic [31:0] b);
      logic [31:0] d;
      if (a >= b)
      begin
         d = a - b;
      end
      else
      begin
         d = a + `SPL_DEG_FULL32 - b;
      end
      return d;
   endfunction : deg_dist

   assign cmd_w = {{2{cmd_pos_i[33]}}, cmd_pos_i};

   // home sits at address zero; offset moves both limits alike
   assign hi_w = {{4{st_r.upper[31]}}, st_r.upper} + {{4{st_r.hoff[31]}}, st_r.hoff};
   assign lo_w = {{4{st_r.lower[31]}}, st_r.lower} + {{4{st_r.hoff[31]}}, st_r.hoff};

   assign over_hi_w = cmd_w - hi_w;
   assign over_lo_w = lo_w - cmd_w;

   assign is_deg = (st_r.unit == spl_pkg::SPL_U_DEG);

   assign hi_d = deg_norm(hi_w);
   assign lo_d = deg_norm(lo_w);
   assign p_d  = deg_norm(cmd_w);

   // range may wrap through zero when lower lies above upper
   always_comb
   begin
      if (lo_d <= hi_d)
      begin
         inside_d = (p_d >= lo_d) && (p_d <= hi_d);
      end
      else
      begin
         inside_d = (p_d >= lo_d) || (p_d <= hi_d);
      end
   end

   // pick the limit reached by the shorter way round
   assign near_lo_d = deg_dist(lo_d, p_d) < deg_dist(p_d, hi_d);

   always_comb
   begin
      if (st_r.obj_dis)
      begin
         en_w = 1'b0;
      end
      else if (is_deg)
      begin
         en_w = (hi_d != lo_d);
      end
      else
      begin
         en_w = ($signed(st_r.upper) > $signed(st_r.lower));
      end
   end

   // homing, velocity and torque leave commands untouched
   assign mode_ok = (st_r.mode == spl_pkg::SPL_M_CSP) ||
                    (st_r.mode == spl_pkg::SPL_M_PP)  ||
                    (st_r.mode == spl_pkg::SPL_M_PT)  ||
                    (st_r.mode == spl_pkg::SPL_M_JOG);

   assign act_w = en_w && mode_ok;

   // csp only: the target must fit a signed 32-bit word
   assign csp_err_w = (st_r.mode == spl_pkg::SPL_M_CSP) &&
                      ((cmd_w > `SPL_MAX32) || (cmd_w < `SPL_MIN32));

   // linear side: which limit is crossed, and whether by too much to trust
   always_comb
   begin
      above_w = 1'b0;
      below_w = 1'b0;
      over_w  = 1'b0;
      if (cmd_w > hi_w)
      begin
         above_w = 1'b1;
         over_w  = (over_hi_w > `SPL_OVER_HI);
      end
      else if (cmd_w < lo_w)
      begin
         below_w = 1'b1;
         over_w  = (over_lo_w > `SPL_OVER_LO);
      end
   end

   // degree side: inside passes normalised, outside snaps to the nearer end
   always_comb
   begin
      deg_clamp_w = 1'b0;
      deg_out_w   = p_d;
      if (!inside_d)
      begin
         deg_clamp_w = 1'b1;
         deg_out_w   = near_lo_d ? lo_d : hi_d;
      end
   end

   always_comb
   begin
      logic        err;
      logic        clamp;
      logic [31:0] out;
      err   = 1'b0;
      clamp = 1'b0;
      out   = cmd_w[31:0];
      st_nxt = st_r;
      st_nxt.eff_vld = 1'b0;
      st_nxt.rdata   = 32'h00000000;

      // register writes first, so a command error in the same cycle wins over all but an accepted reset key, which is applied last
      if (wr_i)
      begin
         if (addr_i == `SPL_A_CTRL)
         begin
            st_nxt.mode = spl_pkg::spl_mode_e'(wdata_i[`SPL_F_MODE_HI:`SPL_F_MODE_LO]);
            st_nxt.unit = spl_pkg::spl_unit_e'(wdata_i[`SPL_F_UNIT_HI:`SPL_F_UNIT_LO]);
            st_nxt.erase_opt = wdata_i[`SPL_F_ERASE];
         end
         else if (addr_i == `SPL_A_UPPER)
         begin
            st_nxt.upper   = wdata_i;
            st_nxt.obj_dis = 1'b0;
         end
         else if (addr_i == `SPL_A_LOWER)
         begin
            st_nxt.lower   = wdata_i;
            st_nxt.obj_dis = 1'b0;
         end
         else if (addr_i == `SPL_A_HOFF)
         begin
            st_nxt.hoff = wdata_i;
         end
         else if (addr_i == `SPL_A_OBJ_MIN)
         begin
            st_nxt.lower   = wdata_i;
            st_nxt.obj_dis = $signed(wdata_i) > $signed(st_r.upper);
         end
         else if (addr_i == `SPL_A_OBJ_MAX)
         begin
            st_nxt.upper   = wdata_i;
            st_nxt.obj_dis = $signed(st_r.lower) > $signed(wdata_i);
         end
         else if (addr_i == `SPL_A_STATUS)
         begin
            // write one to clear the command and key error flags
            if (wdata_i[`SPL_F_CMDERR])
            begin
               st_nxt.cmd_err = 1'b0;
            end
            if (wdata_i[`SPL_F_KEYERR])
            begin
               st_nxt.key_err = 1'b0;
            end
         end
         else if (addr_i == `SPL_A_SWRST)
         begin
            if (wdata_i != `SPL_RST_KEY)
            begin
               st_nxt.key_err = 1'b1;
            end
         end
      end

      if (rd_i)
      begin
         if (addr_i == `SPL_A_CTRL)
         begin
            st_nxt.rdata[`SPL_F_MODE_HI:`SPL_F_MODE_LO] = st_r.mode;
            st_nxt.rdata[`SPL_F_UNIT_HI:`SPL_F_UNIT_LO] = st_r.unit;
            st_nxt.rdata[`SPL_F_ERASE] = st_r.erase_opt;
         end
         else if ((addr_i == `SPL_A_UPPER) || (addr_i == `SPL_A_OBJ_MAX))
         begin
            st_nxt.rdata = st_r.upper;
         end
         else if ((addr_i == `SPL_A_LOWER) || (addr_i == `SPL_A_OBJ_MIN))
         begin
            st_nxt.rdata = st_r.lower;
         end
         else if (addr_i == `SPL_A_HOFF)
         begin
            st_nxt.rdata = st_r.hoff;
         end
         else if (addr_i == `SPL_A_STATUS)
         begin
            st_nxt.rdata[`SPL_F_WARN]   = st_r.warn;
            st_nxt.rdata[`SPL_F_CMDERR] = st_r.cmd_err;
            st_nxt.rdata[`SPL_F_HOMEV]  = st_r.home_valid;
            st_nxt.rdata[`SPL_F_ABSER]  = st_r.abs_erased;
            st_nxt.rdata[`SPL_F_ACTIVE] = act_w;
            st_nxt.rdata[`SPL_F_KEYERR] = st_r.key_err;
         end
      end

      // homing completion restores the reference
      if (home_done_i)
      begin
         st_nxt.home_valid = 1'b1;
         st_nxt.abs_erased = 1'b0;
      end

      // one evaluation per control-cycle command
      if (cmd_vld_i)
      begin
         if (csp_err_w)
         begin
            err = 1'b1;
         end
         if (act_w && is_deg)
         begin
            clamp = deg_clamp_w;
            out   = deg_out_w;
         end
         else if (act_w)
         begin
            if (above_w)
            begin
               clamp = 1'b1;
               out   = hi_w[31:0];
               if (over_w)
               begin
                  err = 1'b1;
               end
            end
            else if (below_w)
            begin
               clamp = 1'b1;
               out   = lo_w[31:0];
               if (over_w)
               begin
                  err = 1'b1;
               end
            end
         end
         if (err)
         begin
            // output held so the loop never sees a bad target
            st_nxt.cmd_err    = 1'b1;
            st_nxt.home_valid = 1'b0;
            if (st_r.erase_opt)
            begin
               st_nxt.abs_erased = 1'b1;
            end
         end
         else
         begin
            st_nxt.eff_pos = out;
            st_nxt.eff_vld = 1'b1;
            st_nxt.warn    = clamp;
         end
      end

      // key accepted: everything back to its power-up state
      if (wr_i && (addr_i == `SPL_A_SWRST) && (wdata_i == `SPL_RST_KEY))
      begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign rdata_o                   = st_r.rdata;
   assign eff_pos_o                 = st_r.eff_pos;
   assign eff_vld_o                 = st_r.eff_vld;
   assign limit_clamp_warning_o     = st_r.warn;
   assign command_range_error_o     = st_r.cmd_err;
   assign abs_position_erased_out_o = st_r.abs_erased;
   assign home_valid_o              = st_r.home_valid;
   assign limit_active_o            = act_w;

endmodule : spl_top

/* File: verif/spl_top_props.sv */
// checker on the limit block ports
// assumes it is bound onto spl_top, one clock, async reset
`timescale 1ns/100ps
module spl_top_props
(
   input wire logic               clk_i,
   input wire logic               sys_rst_i,
   input wire logic               wr_i,
   input wire logic signed [33:0] cmd_pos_i,
   input wire logic               cmd_vld_i,
   input wire logic               home_done_i,
   input wire logic        [31:0] eff_pos_o,
   input wire logic               eff_vld_o,
   input wire logic               limit_clamp_warning_o,
   input wire logic               command_range_error_o,
   input wire logic               abs_position_erased_out_o,
   input wire logic               home_valid_o,
   input wire logic               limit_active_o
);
   logic [31:0] cmd_lo;
   assign cmd_lo = cmd_pos_i[31:0];
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   sequence s_pass;
      (cmd_vld_i && !limit_active_o) ##1 eff_vld_o;
   endsequence
   property p_answer;
      cmd_vld_i |=> eff_vld_o || command_range_error_o;
   endproperty
   a_answer: assert property (p_answer) else $error("command unanswered");
   property p_cause;
      eff_vld_o |-> $past(cmd_vld_i);
   endproperty
   a_cause: assert property (p_cause) else $error("stray valid");
   property p_pass;
      s_pass |-> eff_pos_o == $past(cmd_lo) && !limit_clamp_warning_o;
   endproperty
   a_pass: assert property (p_pass) else $error("inactive command altered");
   property p_warn_hold;
      !eff_vld_o && !$past(wr_i) |-> $stable(limit_clamp_warning_o);
   endproperty
   a_warn_hold: assert property (p_warn_hold) else $error("warning moved");
   property p_pos_hold;
      !eff_vld_o && !$past(wr_i) |-> $stable(eff_pos_o);
   endproperty
   a_pos_hold: assert property (p_pos_hold) else $error("position moved");
   property p_err_sticky;
      $fell(command_range_error_o) |-> $past(wr_i);
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("error dropped");
   property p_abs_sticky;
      $fell(abs_position_erased_out_o) |-> $past(wr_i) || $past(home_done_i);
   endproperty
   a_abs_sticky: assert property (p_abs_sticky) else $error("erased dropped");
   property p_err_erase;
      $rose(command_range_error_o) |-> !home_valid_o && !eff_vld_o;
   endproperty
   a_err_erase: assert property (p_err_erase) else $error("home kept on error");
   property p_home;
      home_done_i && !cmd_vld_i && !wr_i |=> home_valid_o;
   endproperty
   a_home: assert property (p_home) else $error("home not set");
endmodule : spl_top_props
bind spl_top spl_top_props u_props (.clk_i, .sys_rst_i, .wr_i, .cmd_pos_i, .cmd_vld_i,
   .home_done_i, .eff_pos_o, .eff_vld_o, .limit_clamp_warning_o, .command_range_error_o,
   .abs_position_erased_out_o, .home_valid_o, .limit_active_o);

/* File: verif/spl_ctrl_model.sv */
// partner: motion controller feeding one position per control cycle
// assumes callers enter its tasks just after a rising edge
`timescale 1ns/100ps
module spl_ctrl_model
(
   input  wire logic          clk_i,
   input  wire logic          warn_i,
   output logic signed [33:0] cmd_pos_o,
   output logic               cmd_vld_o
);
   initial
   begin
      cmd_pos_o = 34'sh0;
      cmd_vld_o = 1'b0;
   end
   task automatic send(input logic signed [33:0] p);
      @(posedge clk_i);
      cmd_pos_o <= p;
      cmd_vld_o <= 1'b1;
      @(posedge clk_i);
      cmd_vld_o <= 1'b0;
      cmd_pos_o <= ~p; // inverted, so no stale value
      @(posedge clk_i);
      #1;
   endtask : send
   // back to back ramp, halted once a limit is reported
   // warning is looked at mid-cycle, where it has settled
   task automatic ramp(input logic signed [33:0] p, input int step, input int n);
      logic halt;
      halt = 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < n && !halt; i++)
      begin
         cmd_pos_o <= p + 34'(i * step);
         cmd_vld_o <= 1'b1;
         @(negedge clk_i);
         halt = (warn_i === 1'b1);
         @(posedge clk_i);
      end
      cmd_vld_o <= 1'b0;
      cmd_pos_o <= ~cmd_pos_o;
      @(posedge clk_i);
      #1;
   endtask : ramp
endmodule : spl_ctrl_model

/* File: verif/spl_top_bench.sv */
// bench: registers over the plain port, commands through the partner
// assumes spl_top, spl_ctrl_model and the bound checker
`timescale 1ns/100ps
`include "spl_params.svh"
module spl_top_bench;
   logic               clk_i;
   logic               sys_rst_i;
   logic        [7:0]  addr_i;
   logic        [31:0] wdata_i, rdata_o, eff_pos_o;
   logic               wr_i, rd_i, hd_i, cmd_vld_i, eff_vld_o;
   logic signed [33:0] cmd_pos_i;
   logic               warn_o, err_o, abs_o, hv_o, act_o;
   int                 n_errors = 0, checked = 0;
   logic signed [33:0] dp [5] = '{34'sh186a0, 34'sh493e0, 34'sh0bac48, -34'sh2710, 34'sh50910};
   logic        [31:0] de [5] = '{32'h15f90, 32'h4ce78, 32'hafc8, 32'h55730, 32'h50910};
   spl_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmd_pos_i(cmd_pos_i),
      .cmd_vld_i(cmd_vld_i), .home_done_i(hd_i), .eff_pos_o(eff_pos_o),
      .eff_vld_o(eff_vld_o), .limit_clamp_warning_o(warn_o), .command_range_error_o(err_o),
      .abs_position_erased_out_o(abs_o), .home_valid_o(hv_o), .limit_active_o(act_o));
   spl_ctrl_model ctl (.clk_i(clk_i), .warn_i(warn_o), .cmd_pos_o(cmd_pos_i),
      .cmd_vld_o(cmd_vld_i));
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic complete_run;
      if (n_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask : rd
   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      complete_run();
   end
   initial
   begin
      sys_rst_i <= 1'b1;
      addr_i    <= 8'h00;
      wdata_i   <= 32'h0;
      wr_i      <= 1'b0;
      rd_i      <= 1'b0;
      hd_i      <= 1'b0;
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd(`SPL_A_UPPER, 32'h0);
      rd(8'h20, 32'h0);
      chk({31'h0, act_o}, 32'h0);
      ctl.send(34'sh3e8);
      chk(eff_pos_o, 32'h3e8);
      wr(`SPL_A_UPPER, 32'h3e8);
      wr(`SPL_A_LOWER, 32'hfffffe0c);
      wr(`SPL_A_HOFF, 32'h64);
      wr(`SPL_A_CTRL, 32'h1);
      rd(`SPL_A_OBJ_MAX, 32'h3e8);
      rd(`SPL_A_OBJ_MIN, 32'hfffffe0c);
      ctl.send(34'sh7d0);
      chk(eff_pos_o, 32'h44c);
      chk({31'h0, warn_o}, 32'h1);
      ctl.send(-34'sh3e8);
      chk(eff_pos_o, 32'hfffffe70);
      ctl.send(34'sh1f4);
      chk(eff_pos_o, 32'h1f4);
      chk({31'h0, warn_o}, 32'h0);
      ctl.ramp(34'sh384, 100, 8);
      chk(eff_pos_o, 32'h44c);
      chk({31'h0, warn_o}, 32'h1);
      for (int m = 0; m < 7; m++)
      begin
         wr(`SPL_A_CTRL, 32'(m));
         chk({31'h0, act_o}, {31'h0, m < 4});
      end
      wr(`SPL_A_UPPER, 32'h0);
      wr(`SPL_A_LOWER, 32'h3e8);
      wr(`SPL_A_CTRL, 32'h1);
      chk({31'h0, act_o}, 32'h0);
      wr(`SPL_A_CTRL, 32'h21);
      chk({31'h0, act_o}, 32'h1);
      wr(`SPL_A_UPPER, 32'h3e8);
      chk({31'h0, act_o}, 32'h0);
      wr(`SPL_A_CTRL, 32'h24);
      wr(`SPL_A_HOFF, 32'h0);
      wr(`SPL_A_LOWER, 32'h4ce78);
      wr(`SPL_A_UPPER, 32'h6ddd0);
      wr(`SPL_A_CTRL, 32'h21);
      for (int i = 0; i < 5; i++)
      begin
         ctl.send(dp[i]);
         chk(eff_pos_o, de[i]);
      end
      wr(`SPL_A_CTRL, 32'h101);
      wr(`SPL_A_LOWER, 32'h0);
      wr(`SPL_A_UPPER, 32'h3e8);
      wr(`SPL_A_OBJ_MIN, 32'h7d0);
      chk({31'h0, act_o}, 32'h0);
      wr(`SPL_A_LOWER, 32'h0);
      chk({31'h0, act_o}, 32'h1);
      @(posedge clk_i);
      hd_i <= 1'b1;
      @(posedge clk_i);
      hd_i <= 1'b0;
      ctl.send(34'sh0200003e8);
      chk({29'h0, err_o, hv_o, abs_o}, 32'h5);
      chk(eff_pos_o, 32'h50910);
      rd(`SPL_A_STATUS, 32'h1a);
      wr(`SPL_A_STATUS, 32'h2);
      ctl.send(34'sh0200003e7);
      chk({err_o, eff_pos_o[30:0]}, 32'h3e8);
      wr(`SPL_A_UPPER, 32'h0);
      wr(`SPL_A_CTRL, 32'h100);
      ctl.send(34'sh07fffffff);
      chk(eff_pos_o, 32'h7fffffff);
      ctl.send(34'sh080000000);
      chk({31'h0, err_o}, 32'h1);
      wr(`SPL_A_SWRST, 32'h1ea4);
      rd(`SPL_A_STATUS, 32'h2a);
      wr(`SPL_A_SWRST, `SPL_RST_KEY);
      rd(`SPL_A_STATUS, 32'h0);
      rd(`SPL_A_CTRL, 32'h0);
      complete_run();
   end
endmodule : spl_top_bench
